//--- rtl/cgp_gauge.sv
// Operation
// - Count modulator ones per slot; scale to a multi-bit averaged current value.
// - PWM output is high while ramp step is below the held code.
// - Zero current gives code mid-scale, duty nearest one half.
// - Positive current raises duty above half; negative lowers it.
// - Full scale maps to about 95.5 percent, negative full scale 4.5 percent.
// - Duty maps linearly: current = 2.2 x (duty - 0.5) x full scale.
// - Averaging slot is a fixed 50 ms; shorter surges only shift the average.
// - Full scale is a build option of 1 A or 2 A, symmetric.
// - Low shutdown input stops measurement and enters low-current mode.
// - Duty in a slot shows the average of the previous slot.
// - Duty has 128 steps per period; a new code takes effect whole, only at a period start.
// - Output holds high an extra half step: duty is (N+0.5)/128.
`timescale 1ns/1ns
`default_nettype none
module cgp_gauge #(
   parameter int SLOT_CYCLES = cgp_pkg::SLOT_CYC,
   parameter int STEP_CYCLES = cgp_pkg::STEP_CYC,
   parameter int FULL_SCALE = cgp_pkg::FULL_SCALE_MA
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic pdm_bit,
   input wire logic low_power_request_n,
   output logic gauge_output,
   output logic [cgp_pkg::CODE_W-1:0] measured_current,
   output logic code_valid
);
   import cgp_pkg::*;

   typedef enum logic [1:0] {ST_OFF, ST_FILL, ST_RUN} cgp_state_t;

   // 2^32 / slot length, rounded up: rounding down loses the exact half
   // density and shows zero current one code low
   localparam longint RECIP = (64'h1_0000_0000 + longint'(SLOT_CYCLES) - 64'h1)
                              / longint'(SLOT_CYCLES);

   cgp_state_t state;
   logic [31:0] slot_cnt;
   logic [31:0] ones_cnt;
   logic [CODE_W-1:0] pending;
   logic have_pending;
   logic slot_end;
   logic [31:0] next_ones;

   cgp_ramp_if rif ();

   cgp_ramp #(.STEP_CYCLES(STEP_CYCLES)) u_ramp (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .rif(rif)
   );

   // signed density to code
   // Scale-free: the full-scale option only changes how the observer reads duty
   function automatic logic [CODE_W-1:0] cgp_to_code(input logic [31:0] ones);
      logic [63:0] prod;
      logic [15:0] dens;
      logic [31:0] scaled;
      prod = 64'(ones) * 64'(RECIP);
      dens = (prod[63:16] > 48'h00ffff) ? 16'hffff : prod[31:16];
      scaled = 32'(dens) * DUTY_GAIN + DUTY_OFFS;
      return scaled[DUTY_SHIFT +: CODE_W];
   endfunction : cgp_to_code

   assign slot_end = (state != ST_OFF) && (slot_cnt == 32'(SLOT_CYCLES - 1));
   assign next_ones = ones_cnt + {31'h0, pdm_bit};
   assign rif.run = (state != ST_OFF);

   ////////////////////////////////////////////////////////////////////////////
   // shutdown sequencing
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_OFF;
      end else if (!low_power_request_n) begin
         state <= ST_OFF;
      end else begin
         unique case (state)
            ST_OFF: state <= ST_FILL;
            ST_FILL: state <= (have_pending && rif.period_start) ? ST_RUN : ST_FILL;
            ST_RUN: state <= ST_RUN;
            default: state <= ST_OFF;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fixed averaging slot
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_cnt <= CNT_RST;
      end else if (state == ST_OFF || !low_power_request_n || slot_end) begin
         slot_cnt <= CNT_RST;
      end else begin
         slot_cnt <= slot_cnt + 32'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ones_cnt <= CNT_RST;
      end else if (state == ST_OFF || !low_power_request_n || slot_end) begin
         ones_cnt <= CNT_RST;
      end else begin
         ones_cnt <= next_ones;
      end
   end

   // linear duty map of the slot average
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= CODE_RST;
         have_pending <= 1'b0;
      end else if (state == ST_OFF || !low_power_request_n) begin
         have_pending <= 1'b0;
      end else if (slot_end) begin
         pending <= cgp_to_code(next_ones);
         have_pending <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // previous slot shown, swapped only at a frame edge to keep steps whole
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         measured_current <= CODE_RST;
         code_valid <= 1'b0;
      end else if (!low_power_request_n || state == ST_OFF) begin
         code_valid <= 1'b0;
      end else if (rif.period_start && have_pending) begin
         measured_current <= pending;
         code_valid <= 1'b1;
      end
   end

   // comparator with the extra half step
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gauge_output <= 1'b0;
      end else begin
         gauge_output <= low_power_request_n && code_valid
                         && ((rif.step_idx < measured_current)
                             || ((rif.step_idx == measured_current) && rif.half_lo));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_shutdown_low: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !low_power_request_n |=> !gauge_output [*2])
      else $error("output not low in shutdown");

   a_shutdown_stop: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !low_power_request_n |=> (state == ST_OFF) && !code_valid && slot_cnt == 32'h0)
      else $error("measurement not suspended in shutdown");

   a_hold_invalid: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !code_valid |=> !gauge_output)
      else $error("output active before first slot");

   a_code_range: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      code_valid |-> measured_current >= 7'h05 && measured_current <= 7'h7a)
      else $error("code beyond full scale");

   a_frame_swap: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      code_valid && $past(code_valid) && $changed(measured_current) |-> $past(rif.period_start))
      else $error("code changed inside a frame");

   a_ramp_above: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      low_power_request_n && code_valid && rif.step_idx < measured_current |=> gauge_output)
      else $error("output low below code");

   a_ramp_below: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      rif.step_idx > measured_current |=> !gauge_output)
      else $error("output high above code");

   a_half_step: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      low_power_request_n && code_valid && rif.step_idx == measured_current
      && rif.half_lo |=> gauge_output)
      else $error("half step missing");

   a_slot_wrap: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      slot_end && low_power_request_n |=> slot_cnt == 32'h0 && ones_cnt == 32'h0 && have_pending)
      else $error("slot did not close");

   a_zero_mid: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      slot_end && low_power_request_n && ({next_ones[30:0], 1'b0} == 32'(SLOT_CYCLES))
      |=> pending == 7'h40)
      else $error("zero current not mid-scale");

   a_scale_top: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      slot_end && low_power_request_n && next_ones == 32'(SLOT_CYCLES)
      |=> pending == 7'h7a)
      else $error("positive full scale code wrong");

   a_scale_bottom: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      slot_end && low_power_request_n && next_ones == 32'h0
      |=> pending == 7'h05)
      else $error("negative full scale code wrong");

   a_valid_source: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(code_valid) |-> $past(rif.period_start) && $past(have_pending))
      else $error("code shown without a finished slot");

   a_frame_start: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      rif.period_start |-> rif.step_idx == 7'h00 && rif.half_lo)
      else $error("frame does not open at step zero");
endmodule : cgp_gauge
`default_nettype wire

//--- rtl/cgp_pkg.sv
`default_nettype none
package cgp_pkg;
   // Core clock
   localparam int CLK_PERIOD_NS = 10;
   // Averaging slot, in milliseconds and in core cycles
   localparam int SLOT_MS = 50;
   localparam int SLOT_CYC = SLOT_MS * 1000000 / CLK_PERIOD_NS;
   // PWM frame: steps per period and nominal frame rate
   localparam int PWM_STEPS = 128;
   localparam int CODE_W = 7;
   localparam int PWM_FREQ_HZ = 160;
   // Longest step time rounds down
   localparam int STEP_CYC = 1000000000 / (PWM_FREQ_HZ * PWM_STEPS * CLK_PERIOD_NS);
   // Full-scale option in milliamps (1000 or 2000)
   localparam int FULL_SCALE_MA = 1000;
   // Code = 5.82 + 116.36 * density, i.e. duty = 0.5 + f/2.2 less the half step,
   // as Q8 gain and Q24 offset; the sum is floored, which with the half step
   // picks the code nearest the ideal duty
   localparam logic [31:0] DUTY_GAIN = 32'h0000745d;
   localparam logic [31:0] DUTY_OFFS = 32'h05d1e8cd;
   localparam int DUTY_SHIFT = 24;
   // Reset values
   localparam logic [CODE_W-1:0] CODE_RST = 7'h40;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;
endpackage : cgp_pkg
`default_nettype wire

//--- rtl/cgp_ramp_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cgp_ramp_if;
   import cgp_pkg::*;
   logic run;
   logic [CODE_W-1:0] step_idx;
   logic half_lo;
   logic period_start;
   modport ramp (input run, output step_idx, output half_lo, output period_start);
   modport user (output run, input step_idx, input half_lo, input period_start);
endinterface : cgp_ramp_if
`default_nettype wire

//--- rtl/cgp_ramp.sv
`timescale 1ns/1ns
`default_nettype none
module cgp_ramp #(
   parameter int STEP_CYCLES = cgp_pkg::STEP_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   cgp_ramp_if.ramp rif
);
   import cgp_pkg::*;

   logic [31:0] sub;

   ////////////////////////////////////////////////////////////////////////////
   // free-running ramp
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sub <= CNT_RST;
         rif.step_idx <= '0;
      end else if (!rif.run) begin
         sub <= CNT_RST;
         rif.step_idx <= '0;
      end else if (sub == 32'(STEP_CYCLES - 1)) begin
         sub <= CNT_RST;
         rif.step_idx <= rif.step_idx + 7'h01;
      end else begin
         sub <= sub + 32'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rif.half_lo <= 1'b0;
         rif.period_start <= 1'b0;
      end else begin
         rif.half_lo <= rif.run && ((sub == 32'(STEP_CYCLES - 1)) || (sub < 32'(STEP_CYCLES / 2 - 1)));
         rif.period_start <= rif.run && (sub == 32'(STEP_CYCLES - 1))
                             && (rif.step_idx == 7'h7f);
      end
   end
endmodule : cgp_ramp
`default_nettype wire

//--- dv/cgp_duty_meter.sv
`timescale 1ns/1ns
`default_nettype none
module cgp_duty_meter (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic pwm_in,
   output logic [15:0] high_cyc,
   output logic [15:0] period_cyc,
   output logic [15:0] meas_cnt
);
   logic [15:0] hi_run;
   logic [15:0] per_run;
   logic last;
   ////////////////////////////////////////////////////////////////
   // Duty per period
   // Rising edge to rising edge, so a frame is read whole
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         last <= 1'b0;
         hi_run <= 16'h0;
         per_run <= 16'h0;
         high_cyc <= 16'h0;
         period_cyc <= 16'h0;
         meas_cnt <= 16'h0;
      end else begin
         last <= pwm_in;
         if (pwm_in && !last) begin
            high_cyc <= hi_run;
            period_cyc <= per_run;
            meas_cnt <= meas_cnt + 16'h1;
            hi_run <= 16'h1;
            per_run <= 16'h1;
         end else begin
            hi_run <= hi_run + {15'h0, pwm_in};
            per_run <= per_run + 16'h1;
         end
      end
   end
endmodule : cgp_duty_meter
`default_nettype wire

//--- dv/cgp_gauge_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cgp_gauge_tb;
   import cgp_pkg::*;
   localparam int SLOT = 1000;
   localparam int STEP = 8;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic pdm_bit = 1'b0;
   logic low_power_request_n = 1'b1;
   logic gauge_output;
   logic [CODE_W-1:0] measured_current;
   logic code_valid;
   logic [15:0] high_cyc;
   logic [15:0] period_cyc;
   logic [15:0] meas_cnt;
   int n_fail = 0;
   int total_checks = 0;
   int seed = 32'h8542;
   int k = 5;
   int ph = 0;
   always #5 core_clk = ~core_clk;
   cgp_gauge #(.SLOT_CYCLES(SLOT), .STEP_CYCLES(STEP)) u_cgp_gauge (
      .core_clk(core_clk), .rst_n(rst_n), .pdm_bit(pdm_bit),
      .low_power_request_n(low_power_request_n), .gauge_output(gauge_output),
      .measured_current(measured_current), .code_valid(code_valid));
   cgp_duty_meter u_cgp_duty_meter (.core_clk(core_clk), .rst_n(rst_n),
      .pwm_in(gauge_output), .high_cyc(high_cyc), .period_cyc(period_cyc),
      .meas_cnt(meas_cnt));
   // Ten-cycle pattern keeps slot density exact whatever the slot phase
   always @(posedge core_clk) begin
      #1;
      ph <= (ph == 9) ? 0 : ph + 1;
      pdm_bit <= (ph < k);
   end
   ////////////////////////////////////////////////////////////////
   function automatic int exp_code(input int ones);
      return (5820 + 11636 * ones) / 1000;
   endfunction : exp_code
   function automatic int cur_ma(input int h, input int p);
      return 2200 * (2 * h - p) / (2 * p);
   endfunction : cur_ma
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (exp !== got) begin
         n_fail++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic watch(input int n);
      int hits = 0;
      repeat (n) begin
         cyc(1);
         if (gauge_output !== 1'b0 || code_valid !== 1'b0) hits++;
      end
      chk("quiet", 0, hits);
   endtask : watch
   task automatic run_case(input int kk);
      int c;
      int i = 0;
      int cur;
      logic [CODE_W-1:0] n;
      k = kk;
      // Two full slots plus a frame before the code can settle
      cyc(3200);
      c = meas_cnt;
      while (meas_cnt < c + 2 && i < 3000) begin
         cyc(1);
         i++;
      end
      n = measured_current;
      cur = cur_ma(high_cyc, period_cyc);
      chk("frames", 1, i < 3000);
      chk("code", exp_code(kk), n);
      chk("high", STEP * n + STEP / 2, high_cyc);
      chk("period", PWM_STEPS * STEP, period_cyc);
      chk("cur_ok", 1, (cur - (200 * kk - 1000)) inside {[-25:25]});
      chk("valid", 1, code_valid);
   endtask : run_case
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   initial begin
      cyc(3);
      chk("rst_out", 0, gauge_output);
      chk("rst_code", 8'h40, measured_current);
      cyc(3);
      rst_n = 1'b1;
      watch(900);
      run_case(5);
      run_case(0);
      run_case(10);
      repeat (4) run_case(($random(seed) & 32'h7fff_ffff) % 11);
      low_power_request_n = 1'b0;
      cyc(2);
      chk("sd_valid", 0, code_valid);
      watch(2000);
      low_power_request_n = 1'b1;
      watch(900);
      run_case(7);
      // Reset in mid-run must restart the slot and hide the output again
      rst_n = 1'b0;
      cyc(2);
      chk("rst2_valid", 0, code_valid);
      chk("rst2_code", 8'h40, measured_current);
      rst_n = 1'b1;
      watch(900);
      run_case(3);
      results();
   end
   initial begin
      #1_000_000;
      n_fail++;
      results();
   end
endmodule : cgp_gauge_tb
`default_nettype wire
